// ==== acr_ctrl.sv ====
// Register-side control of an 8-bit-bus converter: divider, sampling timer, result layout,
// compare threshold, byte latch, completion flag and start bit.
// Assumes the analog core answers each conversion with a one-cycle done pulse and data.
//
// Overview of operation
// - Converter clock is peripheral clock divided by 4 up to 512, set by three bits.
// - Flag sets on conversion end, or only on a met compare condition.
// - Flag clears when the converter interrupt vector is executed.
// - Writing one to the flag bit clears it; writing zero keeps it.
// - Reading a 16-bit register's low byte copies its high byte into the latch.
// - The byte latch is also an ordinary read/write register.
// - Sampling lasts sample length plus one half periods of the converter clock.
// - A 12-bit calibration value is held; low register holds its low eight bits.
// - Left-adjusted: high byte shows bits 11..4, low upper nibble bits 3..0.
// - Right-adjusted 12-bit: high byte bits 11..8, upper nibble sign-extends if differential.
// - 8-bit form: high byte replicates bit 7 when signed, else zero.
// - Right-adjusted and 8-bit forms show result bits 7..0 low; results read-only.
// - Compare threshold is two's complement when signed conversion is selected.
// - Writing one to the start bit begins a conversion; hardware clears it on start.
// - Writing start while already set has no further effect.
// - Channel start bit aliases the main control start bit.
// - Resolution codes: 00 12-bit right, 10 8-bit right, 11 12-bit left.
// - Gain codes 000..110 are 1x..64x, 111 is one half.
//
// Register map, byte offsets on the register port
// 0x00 channel_control: [7] start, [4:2] gain, [1:0] input kind, [6:5] read zero
// 0x04 clock_divider_ctrl: [2:0] divider select, [7:3] read zero
// 0x06 irq_flag_status: [0] channel_done_flag, a one written clears it
// 0x07 byte_latch: high byte of the last low-byte read, also plain read/write
// 0x08 sample_time_ctrl: [5:0] sample_length, [7:6] read zero
// 0x0c calibration_low: calibration bits 7..0
// 0x0d calibration high: calibration bits 11..8 in [3:0]
// 0x10 result_low and 0x11 result_high: read-only result in the chosen layout
// 0x18 threshold_low and 0x19 threshold_high: 16-bit compare threshold
// 0x20 main start: [0] is the channel start bit seen from the main control side
// 0x21 conversion setup: [1:0] resolution, [2] signed, [4:3] compare mode
// Unmapped offsets read 0x00 and ignore writes.
//
// Compare modes
// 00 flag on every finished conversion
// 01 flag when the result is below the threshold
// 11 flag when the result is above the threshold
// 10 is reserved and behaves as 00
//
// Timing on the register port
// A write takes effect at the edge that samples the write strobe.
// Read data stands in rdata_o for the one cycle after the read strobe, else 0x00.
// Reading a low byte loads byte_latch at the same edge; read the high byte after it.
// Writes reach each byte directly, so a 16-bit write needs no particular order.
//
// Conversion sequence
// A start written at edge n becomes core_o.start and raises sampling at edge n+1.
// Sampling ends after sample_length+1 half-period ticks of the divided clock.
// The core then owns the conversion until it pulses conv_done_i with its data.
// The flag rises one edge after conv_done_i when the mode's condition holds.
//
// Hazards
// The divider runs free, so the first sampling half period can be short.
// A start written while busy is held and taken once the sequencer is idle.
// Only one start can wait; further start writes merge into it.
// A flag set and a clear in the same cycle leave the flag set.
`timescale 1ns/1ns
`include "acr_regs.svh"

module acr_ctrl
    import acr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Analog core
    input wire logic conv_done_i,
    input wire logic [11:0] conv_data_i,
    input wire logic irq_vector_i,
    output acr_core_ctrl_t core_o,
    output logic channel_done_flag_o
);

    ////////////////////////////////////////////////////////////////////////////////
    acr_state_s_t s;
    acr_state_s_t next_s;
    logic [9:0] half_wide;
    logic [9:0] full_wide;
    logic [8:0] half_mask;
    logic [8:0] full_mask;
    logic half_tick;
    logic full_tick;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [15:0] new_val;
    logic cmp_hit;

    // Masks of the low counter bits that span a half and a whole converter period
    assign half_wide = (`ACR_HALF_BASE << s.presc) - 10'h001;
    assign full_wide = (`ACR_FULL_BASE << s.presc) - 10'h001;
    assign half_mask = half_wide[8:0];
    assign full_mask = full_wide[8:0];

    // Ticks when all masked counter bits are ones
    assign half_tick = &(s.div_cnt | ~half_mask);
    assign full_tick = &(s.div_cnt | ~full_mask);

    // Present the stored result in the selected layout
    always_comb begin
        unique case (s.res)
            ACR_RES_12L: begin
                res_hi = s.channel_result[11:4];
                res_lo = {s.channel_result[3:0], 4'h0};
            end
            ACR_RES_8R: begin
                res_hi = s.sgn ? {8{s.channel_result[7]}} : 8'h00;
                res_lo = s.channel_result[7:0];
            end
            default: begin
                // Reserved code 01 behaves as 12-bit right-adjusted
                res_hi = {(s.kind[1] ? {4{s.channel_result[11]}} : 4'h0), s.channel_result[11:8]};
                res_lo = s.channel_result[7:0];
            end
        endcase
    end

    // Numeric value of an arriving result, sign-extended in signed operation
    always_comb begin
        if (s.res == ACR_RES_8R) begin
            new_val = s.sgn ? {{8{conv_data_i[7]}}, conv_data_i[7:0]} : {8'h00, conv_data_i[7:0]};
        end else begin
            new_val = s.sgn ? {{4{conv_data_i[11]}}, conv_data_i} : {4'h0, conv_data_i};
        end
    end

    // Compare condition against the threshold
    always_comb begin
        unique case (s.cmp_mode)
            ACR_CMP_BELOW: begin
                cmp_hit = s.sgn ? ($signed(new_val) < $signed(s.compare_threshold))
                                : (new_val < s.compare_threshold);
            end
            ACR_CMP_ABOVE: begin
                cmp_hit = s.sgn ? ($signed(new_val) > $signed(s.compare_threshold))
                                : (new_val > s.compare_threshold);
            end
            default: begin
                cmp_hit = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: bus access, divider, sequencer, flag
    always_comb begin
        next_s = s;
        next_s.div_cnt = s.div_cnt + 9'h001;
        next_s.clk_en = full_tick;
        next_s.conv_start = 1'b0;
        next_s.rdata = `ACR_RST_BYTE;

        // Register writes
        if (wr_i) begin
            unique case (addr_i)
                // Start request, gain and input kind
                `ACR_OFF_CHAN_CTRL: begin
                    next_s.start = s.start | wdata_i[`ACR_START_BIT];
                    next_s.gain = acr_gain_t'(wdata_i[4:2]);
                    next_s.kind = wdata_i[1:0];
                end
                // Alias of the start bit from the main control side
                `ACR_OFF_MAIN_START: begin
                    next_s.start = s.start | wdata_i[`ACR_MAIN_START_BIT];
                end
                // Resolution, signedness and compare mode
                `ACR_OFF_CONV_CFG: begin
                    next_s.res = acr_res_t'(wdata_i[1:0]);
                    next_s.sgn = wdata_i[2];
                    next_s.cmp_mode = acr_cmp_t'(wdata_i[4:3]);
                end
                // Divider select
                `ACR_OFF_PRESC: begin
                    next_s.presc = wdata_i[2:0];
                end
                // A one clears the flag, a zero keeps it
                `ACR_OFF_FLAGS: begin
                    if (wdata_i[`ACR_FLAG_BIT]) begin
                        next_s.channel_done_flag = 1'b0;
                    end
                end
                // Byte latch as a plain register
                `ACR_OFF_LATCH: begin
                    next_s.latch = wdata_i;
                end
                // Sampling length
                `ACR_OFF_SAMP: begin
                    next_s.sample_length = wdata_i[5:0];
                end
                // Calibration low byte
                `ACR_OFF_CAL_LO: begin
                    next_s.cal[7:0] = wdata_i;
                end
                // Calibration high nibble
                `ACR_OFF_CAL_HI: begin
                    next_s.cal[11:8] = wdata_i[3:0];
                end
                // Threshold low byte
                `ACR_OFF_THR_LO: begin
                    next_s.compare_threshold[7:0] = wdata_i;
                end
                // Threshold high byte, sign on top in signed mode
                `ACR_OFF_THR_HI: begin
                    next_s.compare_threshold[15:8] = wdata_i;
                end
                default: begin
                    // Result registers and unmapped offsets ignore writes
                end
            endcase
        end

        // Register reads, data stands in the following cycle only; reserved bits read zero
        if (rd_i) begin
            unique case (addr_i)
                // Start request, gain and input kind
                `ACR_OFF_CHAN_CTRL: begin
                    next_s.rdata = {s.start, 2'h0, s.gain, s.kind};
                end
                // Alias of the start bit
                `ACR_OFF_MAIN_START: begin
                    next_s.rdata = {7'h00, s.start};
                end
                // Resolution, signedness and compare mode
                `ACR_OFF_CONV_CFG: begin
                    next_s.rdata = {3'h0, s.cmp_mode, s.sgn, s.res};
                end
                // Divider select
                `ACR_OFF_PRESC: begin
                    next_s.rdata = {5'h00, s.presc};
                end
                // Completion flag
                `ACR_OFF_FLAGS: begin
                    next_s.rdata = {7'h00, s.channel_done_flag};
                end
                // Byte latch as a plain register
                `ACR_OFF_LATCH: begin
                    next_s.rdata = s.latch;
                end
                // Sampling length
                `ACR_OFF_SAMP: begin
                    next_s.rdata = {2'h0, s.sample_length};
                end
                // Low bytes of the 16-bit pairs load the latch
                `ACR_OFF_CAL_LO: begin
                    next_s.rdata = s.cal[7:0];
                    next_s.latch = {4'h0, s.cal[11:8]};
                end
                `ACR_OFF_RES_LO: begin
                    next_s.rdata = res_lo;
                    next_s.latch = res_hi;
                end
                `ACR_OFF_THR_LO: begin
                    next_s.rdata = s.compare_threshold[7:0];
                    next_s.latch = s.compare_threshold[15:8];
                end
                // High bytes of the 16-bit pairs come from the latch
                `ACR_OFF_CAL_HI, `ACR_OFF_RES_HI, `ACR_OFF_THR_HI: begin
                    next_s.rdata = s.latch;
                end
                // Unmapped offsets read zero
                default: begin
                    next_s.rdata = `ACR_RST_BYTE;
                end
            endcase
        end

        // Vector execution clears the flag before a new event can set it
        if (irq_vector_i) begin
            next_s.channel_done_flag = 1'b0;
        end

        // Sequencer acts after the bus so a write in the taking cycle is absorbed
        unique case (s.fsm)
            ACR_IDLE: begin
                if (s.start) begin
                    next_s.start = 1'b0;
                    next_s.conv_start = 1'b1;
                    next_s.sampling = 1'b1;
                    next_s.samp_cnt = s.sample_length;
                    next_s.fsm = ACR_SAMPLE;
                end
            end
            ACR_SAMPLE: begin
                if (half_tick) begin
                    if (s.samp_cnt == 6'h00) begin
                        next_s.sampling = 1'b0;
                        next_s.fsm = ACR_CONVERT;
                    end else begin
                        next_s.samp_cnt = s.samp_cnt - 6'h01;
                    end
                end
            end
            ACR_CONVERT: begin
                if (conv_done_i) begin
                    next_s.channel_result = conv_data_i;
                    next_s.fsm = ACR_IDLE;
                    if (cmp_hit) begin
                        next_s.channel_done_flag = 1'b1;
                    end
                end
            end
            default: begin
                // Illegal code: back to idle with sampling off
                next_s.fsm = ACR_IDLE;
                next_s.sampling = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Register port and flag outputs straight from the state register
    assign rdata_o = s.rdata;
    assign channel_done_flag_o = s.channel_done_flag;

    // Core controls straight from the state register
    assign core_o.clk_en = s.clk_en;
    assign core_o.start = s.conv_start;
    assign core_o.sampling = s.sampling;
    assign core_o.gain = s.gain;
    assign core_o.input_kind_select = s.kind;
    assign core_o.signedness_select = s.sgn;
    assign core_o.res = s.res;
    assign core_o.cal = s.cal;

endmodule // acr_ctrl

// ==== acr_ctrl_checker.sv ====
// Concurrent checks for the converter control block.
// Assumes it is bound to acr_ctrl and sees only that module's ports.
`timescale 1ns/1ns
module acr_ctrl_checker
    import acr_pkg::*;
(
    // Clock, reset and register port
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Analog core side
    input wire logic conv_done_i,
    input wire logic [11:0] conv_data_i,
    input wire logic irq_vector_i,
    input wire acr_core_ctrl_t core_o,
    input wire logic channel_done_flag_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    // Divider pulses are at least four cycles apart
    property p_div_gap; core_o.clk_en |=> !core_o.clk_en [*3]; endproperty
    a_div_gap: assert property (p_div_gap) else $error("converter clock pulses too close");
    // Flag writes: one clears, zero keeps
    property p_wr_one;
        wr_i && addr_i == 8'h06 && wdata_i[0] && !conv_done_i && !$past(conv_done_i) |=> !channel_done_flag_o;
    endproperty
    a_wr_one: assert property (p_wr_one) else $error("flag survived a clearing write");
    property p_wr_zero;
        wr_i && addr_i == 8'h06 && !wdata_i[0] && !irq_vector_i && channel_done_flag_o |=> channel_done_flag_o;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("flag lost on a zero write");
    // Vector execution clears the flag
    property p_irq; irq_vector_i && !conv_done_i && !$past(conv_done_i) |=> !channel_done_flag_o; endproperty
    a_irq: assert property (p_irq) else $error("flag survived the vector");
    // Flag only rises after a finished conversion
    property p_cause; $rose(channel_done_flag_o) |-> $past(conv_done_i) || $past(conv_done_i, 2); endproperty
    a_cause: assert property (p_cause) else $error("flag rose without a conversion");
    // Start pulse is one cycle and opens sampling
    property p_start; core_o.start |-> core_o.sampling ##1 !core_o.start; endproperty
    a_start: assert property (p_start) else $error("start pulse malformed");
    // Reserved bits read zero
    property p_rsvd_flag; rd_i && addr_i == 8'h06 |=> rdata_o[7:1] == 7'h00; endproperty
    a_rsvd_flag: assert property (p_rsvd_flag) else $error("flag register reserved bits set");
    property p_rsvd_div; rd_i && addr_i == 8'h04 |=> rdata_o[7:3] == 5'h00; endproperty
    a_rsvd_div: assert property (p_rsvd_div) else $error("divider register reserved bits set");
    // Read data stands only after a read
    property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
    // Main scenarios
    c_flag: cover property ($rose(channel_done_flag_o));
    c_start: cover property (core_o.start);
    c_clr: cover property (wr_i && addr_i == 8'h06 && wdata_i[0] && channel_done_flag_o);
endmodule // acr_ctrl_checker

bind acr_ctrl acr_ctrl_checker u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
    .irq_vector_i(irq_vector_i), .core_o(core_o), .channel_done_flag_o(channel_done_flag_o));

// ==== acr_ctrl_tb.sv ====
// Self-checking bench for the converter control block.
// Drives the register port and plays the analog core itself.
`timescale 1ns/1ns
module acr_ctrl_tb;
    import acr_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic conv_done_i = 1'b0;
    logic [11:0] conv_data_i = 12'h000;
    logic irq_vector_i = 1'b0;
    logic [7:0] rdata_o;
    acr_core_ctrl_t core_o;
    logic channel_done_flag_o;
    int err_total = 0;
    int comparisons = 0;
    int starts = 0;
    int n0, dur, gap;
    logic [7:0] regs [8] = '{8'h00, 8'h04, 8'h06, 8'h07, 8'h08, 8'h0c, 8'h18, 8'h19};
    logic [7:0] cfg [5] = '{8'h00, 8'h04, 8'h06, 8'h02, 8'h03};
    logic [7:0] ctl [5] = '{8'h80, 8'h82, 8'h81, 8'h81, 8'h80};
    logic [7:0] elo [5] = '{8'hc3, 8'hc3, 8'hc3, 8'hc3, 8'h30};
    logic [7:0] ehi [5] = '{8'h09, 8'hf9, 8'hff, 8'h00, 8'h9c};
    acr_ctrl dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
        .irq_vector_i(irq_vector_i), .core_o(core_o), .channel_done_flag_o(channel_done_flag_o));
    ////////////////////////////////////////
    // Clock and start pulse counter
    initial forever #50 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (core_o.start === 1'b1) starts++;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 chk({8'h00, rdata_o}, {8'h00, e});
    endtask
    // Waits out sampling, then answers as the core with data d
    task automatic conv(input logic [11:0] d);
        for (int k = 0; k < 50 && core_o.sampling !== 1'b1; k++) @(posedge sys_clk_i) #1;
        dur = 0;
        while (core_o.sampling === 1'b1 && dur < 9000) begin
            @(posedge sys_clk_i) #1;
            dur++;
        end
        @(posedge sys_clk_i);
        conv_data_i <= d;
        conv_done_i <= 1'b1;
        @(posedge sys_clk_i);
        conv_done_i <= 1'b0;
    endtask
    task automatic wait_en();
        gap = 0;
        do begin
            @(posedge sys_clk_i) #1;
            gap++;
        end while (core_o.clk_en !== 1'b1 && gap < 600);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #2000000;
        err_total++;
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        foreach (regs[i]) rd(regs[i], 8'h00);
        wr(8'h07, 8'ha5);
        rd(8'h07, 8'ha5);
        wr(8'h0c, 8'h3c);
        wr(8'h0d, 8'hf5);
        rd(8'h0c, 8'h3c);
        rd(8'h0d, 8'h05);
        chk({4'h0, core_o.cal}, 16'h053c);
        wr(8'h19, 8'h80);
        wr(8'h18, 8'h01);
        rd(8'h18, 8'h01);
        rd(8'h19, 8'h80);
        rd(8'h07, 8'h80);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h07);
        wr(8'h08, 8'hff);
        rd(8'h08, 8'h3f);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h00);
        wr(8'h00, 8'h7f);
        rd(8'h00, 8'h1f);
        for (int g = 0; g < 8; g++) begin
            wr(8'h00, 8'(g << 2));
            repeat (2) @(posedge sys_clk_i) #1;
            chk({13'h0, core_o.gain}, 16'(g));
        end
        for (int p = 0; p < 8; p++) begin
            wr(8'h04, 8'(p));
            repeat (3) wait_en();
            chk(16'(gap), 16'(4 << p));
        end
        wr(8'h04, 8'h03);
        wr(8'h08, 8'h05);
        for (int i = 0; i < 5; i++) begin
            wr(8'h21, cfg[i]);
            wr(8'h10, 8'h55);
            wr(8'h00, ctl[i]);
            conv(12'h9c3);
            chk({15'h0, dur > 80 && dur < 97}, 16'h1);
            chk({14'h0, core_o.res}, 16'(cfg[i][1:0]));
            chk({13'h0, core_o.signedness_select, core_o.input_kind_select}, 16'({cfg[i][2], ctl[i][1:0]}));
            rd(8'h00, ctl[i] & 8'h1f);
            rd(8'h10, elo[i]);
            rd(8'h11, ehi[i]);
            rd(8'h07, ehi[i]);
            rd(8'h06, 8'h01);
            chk({15'h0, channel_done_flag_o}, 16'h0001);
            wr(8'h06, 8'h00);
            rd(8'h06, 8'h01);
            wr(8'h06, 8'h01);
            rd(8'h06, 8'h00);
        end
        wr(8'h21, 8'h1c);
        wr(8'h18, 8'h00);
        wr(8'h19, 8'h00);
        wr(8'h00, 8'h80);
        conv(12'h9c3);
        rd(8'h06, 8'h00);
        wr(8'h21, 8'h0c);
        wr(8'h18, 8'hf0);
        wr(8'h19, 8'hff);
        wr(8'h00, 8'h80);
        conv(12'h9c3);
        rd(8'h06, 8'h01);
        @(posedge sys_clk_i);
        irq_vector_i <= 1'b1;
        @(posedge sys_clk_i);
        irq_vector_i <= 1'b0;
        rd(8'h06, 8'h00);
        chk({15'h0, channel_done_flag_o}, 16'h0000);
        n0 = starts;
        wr(8'h20, 8'h01);
        wr(8'h00, 8'h80);
        wr(8'h20, 8'h01);
        rd(8'h20, 8'h01);
        rd(8'h00, 8'h80);
        conv(12'h123);
        conv(12'h123);
        repeat (200) @(posedge sys_clk_i);
        chk(16'(starts - n0), 16'h2);
        complete_run();
    end
endmodule // acr_ctrl_tb

// ==== acr_pkg.sv ====
// Types shared by the converter control block.
// Assumes acr_regs.svh sits in the include path.
package acr_pkg;
    // Conversion sequencer states
    typedef enum logic [1:0] {ACR_IDLE, ACR_SAMPLE, ACR_CONVERT} acr_state_t;
    // Result layout codes, 01 is reserved
    typedef enum logic [1:0] {
        ACR_RES_12R = 2'h0, ACR_RES_RSVD = 2'h1, ACR_RES_8R = 2'h2, ACR_RES_12L = 2'h3
    } acr_res_t;
    // Completion or compare condition for the flag
    typedef enum logic [1:0] {
        ACR_CMP_DONE = 2'h0, ACR_CMP_BELOW = 2'h1, ACR_CMP_RSVD = 2'h2, ACR_CMP_ABOVE = 2'h3
    } acr_cmp_t;
    // Gain codes: 1x to 64x in powers of two, then one half
    typedef enum logic [2:0] {
        ACR_G1 = 3'h0, ACR_G2 = 3'h1, ACR_G4 = 3'h2, ACR_G8 = 3'h3,
        ACR_G16 = 3'h4, ACR_G32 = 3'h5, ACR_G64 = 3'h6, ACR_GHALF = 3'h7
    } acr_gain_t;
    // Controls handed to the analog core
    typedef struct packed {
        logic clk_en;
        logic start;
        logic sampling;
        acr_gain_t gain;
        logic [1:0] input_kind_select;
        logic signedness_select;
        acr_res_t res;
        logic [11:0] cal;
    } acr_core_ctrl_t;
    // Complete block state
    typedef struct packed {
        logic start;
        acr_gain_t gain;
        logic [1:0] kind;
        logic [2:0] presc;
        logic [5:0] sample_length;
        logic [11:0] cal;
        logic [15:0] compare_threshold;
        logic [7:0] latch;
        logic channel_done_flag;
        acr_res_t res;
        logic sgn;
        acr_cmp_t cmp_mode;
        logic [11:0] channel_result;
        logic [8:0] div_cnt;
        acr_state_t fsm;
        logic [5:0] samp_cnt;
        logic [7:0] rdata;
        logic clk_en;
        logic conv_start;
        logic sampling;
    } acr_state_s_t;
endpackage

// ==== acr_regs.svh ====
// Register map, field positions, reset values and widths of the converter control block.
// Assumes inclusion by the design module only.
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH
`define ACR_OFF_CHAN_CTRL 8'h00
`define ACR_OFF_PRESC 8'h04
`define ACR_OFF_FLAGS 8'h06
`define ACR_OFF_LATCH 8'h07
`define ACR_OFF_SAMP 8'h08
`define ACR_OFF_CAL_LO 8'h0c
`define ACR_OFF_CAL_HI 8'h0d
`define ACR_OFF_RES_LO 8'h10
`define ACR_OFF_RES_HI 8'h11
`define ACR_OFF_THR_LO 8'h18
`define ACR_OFF_THR_HI 8'h19
`define ACR_OFF_MAIN_START 8'h20
`define ACR_OFF_CONV_CFG 8'h21
`define ACR_START_BIT 7
`define ACR_MAIN_START_BIT 0
`define ACR_FLAG_BIT 0
`define ACR_RST_BYTE 8'h00
`define ACR_DIV_W 9
`define ACR_HALF_BASE 10'h002
`define ACR_FULL_BASE 10'h004
`endif
